// ---- logic/hps_pkg.sv ----
package hps_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RATIO_ADDR = 8'hA0;  // Integer decimation ratio
    localparam logic [7:0] REG_ACL_ADDR   = 8'hA1;  // Accumulation length
    localparam logic [7:0] REG_CTRL_ADDR  = 8'hA2;  // Prefilter and gain control

    localparam int CHROMA_SEL_LSB = 6;  // chroma_prefilter_select [7:6]
    localparam int LUMA_SEL_LSB   = 4;  // luma_prefilter_select [5:4]
    localparam int WEIGHT_BIT     = 3;  // inner_weight_select
    localparam int SHIFT_LSB      = 0;  // gain_renorm_shift [2:0]

    localparam logic [5:0] RATIO_RST = 6'h01;
    localparam logic [5:0] ACL_RST   = 6'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // ------------------------------------------------------------------
    // Prefilter codes and kernel normalisation shifts
    // ------------------------------------------------------------------
    localparam logic [1:0] PF_BYPASS = 2'h0;
    localparam logic [1:0] PF_121    = 2'h1;
    localparam logic [1:0] PF_WIDE   = 2'h2;
    localparam logic [1:0] PF_12221  = 2'h3;

    localparam int SH_121   = 2;  // Kernel sum 4
    localparam int SH_12221 = 3;  // Kernel sum 8
    localparam int SH_WIDE  = 5;  // Kernel sum 32 (luma taps scaled by 4)

    localparam int NTAPS      = 7;
    localparam int CENTER_TAP = 3;
    localparam int PIX_W      = 8;
    localparam int ACC_W      = 16;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------------
    // Pixel carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic       sol;   // First pixel of a line
        logic       eol;   // Last pixel of a line
    } pix_t;

    localparam int PIX_T_W = 18;

endpackage : hps_pkg

// ---- logic/horizontal_prescaler_filter.sv ----
`timescale 1ns/10ps

// --------------------------------------------------------------------------
// Output FIFO
// --------------------------------------------------------------------------
module pix_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_nxt;
    logic     do_wr;
    logic     do_rd;

    // Honest flags straight from the occupancy count
    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Pointer and count update; pointers wrap since depth is a power of two
    always_comb begin
        st_nxt = st_r;
        if (do_wr) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp           = st_r.wp + AW'(1);
        end
        st_nxt.rp  = st_r.rp + AW'(do_rd);
        st_nxt.cnt = st_r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : pix_fifo

// --------------------------------------------------------------------------
// Horizontal prescaler
// --------------------------------------------------------------------------
// Contract
// - Averaging DC gain is 1 at length zero, else (weight bit + 1) times accumulation length plus (1 - weight bit).
// - Luma and chroma share one line timing and one decimation ratio but own filter selects.
// - First and last output pixel of each line are raw copies of source samples.
// - Select 00 bypasses, 01 applies 1-2-1, 11 applies 1-2-2-2-1, on both paths.
// - Select 10 applies luma -1,1,1.75,4.5,1.75,1,-1 and chroma 3,8,10,8,3.
// - Chroma select sits in bits 7:6 and luma select in bits 5:4 of the control register.
// - Weight bit clear weighs all samples one; set weighs ends one and inner samples two.
// - The accumulated sum is divided by two to the power of the 3-bit shift.
module horizontal_prescaler_filter
    import hps_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire pix_t       in_pix,
    output logic            out_valid,
    input  wire logic       out_ready,
    output pix_t            out_pix
);

    typedef struct packed {
        logic [5:0]                        ratio;
        logic [5:0]                        acl;
        logic [7:0]                        ctrl;
        logic [7:0]                        rdata;
        logic [1:0][NTAPS-1:0][PIX_W-1:0]  taps;   // [0] luma, [1] chroma
        logic [5:0]                        phase;
        logic [1:0]                        act;
        logic [1:0][5:0]                   cnt;
        logic [1:0][1:0][ACC_W-1:0]        acc;    // [window][path]
        logic                              nxt;
    } core_t;

    core_t st_r;
    core_t st_nxt;
    logic  fifo_in_ready;
    logic  push;
    pix_t  push_pix;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic signed [15:0] ext(input logic [7:0] x);
        ext = signed'({8'h00, x});
    endfunction : ext
    // Kernel sums are all powers of two, so normalisation is a plain shift
    function automatic logic [7:0] fir(input logic [NTAPS-1:0][PIX_W-1:0] t,
                                       input logic [1:0] sel,
                                       input logic chroma);
        logic signed [15:0] s;
        logic signed [15:0] r;
        s = ext(t[CENTER_TAP]);
        case (sel)
            PF_121: begin
                s = ext(t[2]) + (ext(t[3]) <<< 1) + ext(t[4]);
                r = s >>> SH_121;
            end
            PF_12221: begin
                s = ext(t[1]) + (ext(t[2]) <<< 1) + (ext(t[3]) <<< 1)
                  + (ext(t[4]) <<< 1) + ext(t[5]);
                r = s >>> SH_12221;
            end
            PF_WIDE: begin
                if (chroma) begin
                    s = 16'sd3 * ext(t[1]) + 16'sd8 * ext(t[2]) + 16'sd10 * ext(t[3])
                      + 16'sd8 * ext(t[4]) + 16'sd3 * ext(t[5]);
                end else begin
                    // Peak positive sum is about forty times full scale
                    s = 16'sd4 * (ext(t[1]) + ext(t[5]) - ext(t[0]) - ext(t[6]))
                      + 16'sd7 * (ext(t[2]) + ext(t[4])) + 16'sd18 * ext(t[3]);
                end
                r = s >>> SH_WIDE;
            end
            default: r = s;
        endcase
        // Negative lobes of the wide luma kernel can undershoot black
        fir = (r < 16'sd0) ? 8'h00 : ((r > 16'sd255) ? 8'hFF : r[7:0]);
    endfunction : fir
    // Contribution of one sample to a window at position c
    function automatic logic [ACC_W-1:0] wsample(input logic [7:0] f,
                                                 input logic [5:0] c,
                                                 input logic [5:0] acl,
                                                 input logic w2);
        wsample = (w2 && (c != 6'h00) && (c != acl)) ? {7'h00, f, 1'b0}
                                                     : {8'h00, f};
    endfunction : wsample
    function automatic logic [7:0] renorm(input logic [ACC_W-1:0] a,
                                          input logic [2:0] sh);
        logic [ACC_W-1:0] q;
        q = a >> sh;
        // Saturation only bites when the shift is set too small
        renorm = (q > 16'h00FF) ? 8'hFF : q[7:0];
    endfunction : renorm

    // ------------------------------------------------------------------
    // Register access, prefilter and decimator
    // ------------------------------------------------------------------
    assign in_ready = fifo_in_ready;

    always_comb begin
        logic [1:0][7:0]  filt;
        logic [1:0][1:0]  sel;
        logic [1:0]       done;
        logic [7:0]       res_y;
        logic [7:0]       res_c;
        logic             w2;
        logic [2:0]       sh;
        logic             k;
        filt   = '0;
        done   = '0;
        res_y  = '0;
        res_c  = '0;
        k      = 1'b0;
        st_nxt = st_r;
        push     = 1'b0;
        push_pix = '0;
        w2  = st_r.ctrl[WEIGHT_BIT];
        sh  = st_r.ctrl[SHIFT_LSB +: 3];
        sel[0] = st_r.ctrl[LUMA_SEL_LSB +: 2];
        sel[1] = st_r.ctrl[CHROMA_SEL_LSB +: 2];

        // Register writes; unmapped addresses are ignored
        if (reg_wr) begin
            case (reg_addr)
                REG_RATIO_ADDR: st_nxt.ratio = reg_wdata[5:0];
                REG_ACL_ADDR:   st_nxt.acl   = reg_wdata[5:0];
                REG_CTRL_ADDR:  st_nxt.ctrl  = reg_wdata;
                default:        st_nxt.ctrl  = st_nxt.ctrl;
            endcase
        end
        case (reg_addr)
            REG_RATIO_ADDR: st_nxt.rdata = {2'h0, st_r.ratio};
            REG_ACL_ADDR:   st_nxt.rdata = {2'h0, st_r.acl};
            REG_CTRL_ADDR:  st_nxt.rdata = st_r.ctrl;
            default:        st_nxt.rdata = 8'h00;
        endcase

        if (in_valid && fifo_in_ready) begin
            // Line start fills the taps with the first sample so edges stay flat
            if (in_pix.sol) begin
                st_nxt.taps[0] = {NTAPS{in_pix.luma}};
                st_nxt.taps[1] = {NTAPS{in_pix.chroma}};
            end else begin
                st_nxt.taps[0] = {st_r.taps[0][NTAPS-2:0], in_pix.luma};
                st_nxt.taps[1] = {st_r.taps[1][NTAPS-2:0], in_pix.chroma};
            end
            for (int p = 0; p < 2; p++) begin
                filt[p] = fir(st_nxt.taps[p], sel[p], p[0]);
            end

            if (in_pix.sol || in_pix.eol) begin
                // Edge samples go out untouched; open windows are dropped
                push          = 1'b1;
                push_pix      = in_pix;
                st_nxt.act    = 2'b00;
                st_nxt.phase  = 6'h00;
                st_nxt.nxt    = 1'b0;
            end else begin
                // Running windows; both paths share the window timing
                for (int j = 0; j < 2; j++) begin
                    if (st_r.act[j]) begin
                        for (int p = 0; p < 2; p++) begin
                            st_nxt.acc[j][p] = st_r.acc[j][p]
                                + wsample(filt[p], st_r.cnt[j], st_r.acl, w2);
                        end
                        if (st_r.cnt[j] == st_r.acl) begin
                            done[j]       = 1'b1;
                            st_nxt.act[j] = 1'b0;
                        end else begin
                            st_nxt.cnt[j] = st_r.cnt[j] + 6'h01;
                        end
                    end
                end
                // A new window opens every ratio samples, alternating slots
                if (st_r.phase == 6'h00) begin
                    k = st_r.nxt;
                    for (int p = 0; p < 2; p++) begin
                        st_nxt.acc[k][p] = {8'h00, filt[p]};
                    end
                    st_nxt.cnt[k] = 6'h01;
                    st_nxt.act[k] = (st_r.acl != 6'h00);
                    done[k]       = done[k] | (st_r.acl == 6'h00);
                    st_nxt.nxt    = ~st_r.nxt;
                end
                // A zero ratio behaves as one rather than locking up
                st_nxt.phase = ((st_r.phase + 6'h01) >= st_r.ratio) ? 6'h00
                             : st_r.phase + 6'h01;
                // With legal lengths at most one window closes per sample
                if (done != 2'b00) begin
                    k        = !done[0];
                    res_y    = renorm(st_nxt.acc[k][0], sh);
                    res_c    = renorm(st_nxt.acc[k][1], sh);
                    push     = 1'b1;
                    push_pix = '{luma: res_y, chroma: res_c, sol: 1'b0, eol: 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{ratio: RATIO_RST, acl: ACL_RST, ctrl: CTRL_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;

    // ------------------------------------------------------------------
    // Output buffer; its back-pressure stalls the input
    // ------------------------------------------------------------------
    pix_fifo #(
        .WIDTH (PIX_T_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_pix),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_pix)
    );

endmodule : horizontal_prescaler_filter

// ---- sim/hpf_chk.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port checker for the horizontal prescaler
// ----------------------------------------------------------------------
module hpf_chk
    import hps_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire pix_t       in_pix,
    input wire logic       out_valid,
    input wire logic       out_ready,
    input wire pix_t       out_pix
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Read-back follows the address of the cycle before
    unmapped_read_a: assert property (($past(reg_addr) < REG_RATIO_ADDR
        || $past(reg_addr) > REG_CTRL_ADDR) |-> reg_rdata == 8'h00) else $error("unmapped read");
    narrow_field_a: assert property (($past(reg_addr) == REG_RATIO_ADDR
        || $past(reg_addr) == REG_ACL_ADDR) |-> reg_rdata[7:6] == 2'h0) else $error("wide field");
    ctrl_readback_a: assert property ((reg_wr && reg_addr == REG_CTRL_ADDR) ##1
        (!reg_wr && reg_addr == REG_CTRL_ADDR) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("control read-back wrong");
    // Output side holds while stalled; a word only appears after an accept
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
        else $error("output changed under stall");
    push_cause_a: assert property ($rose(out_valid) |-> $past(in_valid && in_ready))
        else $error("output without input");
    full_valid_a: assert property (!in_ready |-> out_valid) else $error("full but empty");
    full_stays_a: assert property (!in_ready && !out_ready |=> !in_ready)
        else $error("space without a pop");
    empty_ready_a: assert property (!out_valid |-> in_ready) else $error("empty but refused");
    // An edge sample into an empty buffer comes out unchanged
    edge_raw_a: assert property (in_valid && in_ready && (in_pix.sol || in_pix.eol)
        && !out_valid |=> out_valid && out_pix == $past(in_pix)) else $error("edge not raw");
endmodule : hpf_chk

bind horizontal_prescaler_filter hpf_chk u_chk (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix),
    .out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));

// ---- sim/pix_sink.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Downstream fine-scaler stand-in
// ----------------------------------------------------------------------
module pix_sink
    import hps_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic out_valid,
    input  wire pix_t out_pix,
    output logic      out_ready
);
    logic [1:0] phase_r;
    pix_t       got[$];

    // Slow mode accepts one cycle in four, so the buffer fills up
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r   <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            phase_r   <= phase_r + 2'h1;
            out_ready <= !slow || phase_r == 2'h3;
            if (out_valid && out_ready) begin
                got.push_back(out_pix);
            end
        end
    end
endmodule : pix_sink

// ---- sim/testbench.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------
module testbench
    import hps_pkg::*;
;
    logic       clk, rst, reg_wr, in_valid, in_ready, out_valid, out_ready, slow;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    pix_t       in_pix, out_pix;
    int         fail_count, compares;

    horizontal_prescaler_filter u_dut (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix),
        .out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));
    pix_sink u_sink (.clk(clk), .rst(rst), .slow(slow), .out_valid(out_valid),
        .out_pix(out_pix), .out_ready(out_ready));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task stop_test;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task chk(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is registered, so look two edges after the address
    task rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 chk({10'h000, reg_rdata}, {10'h000, e});
    endtask : rdc

    // Hold the sample until it is taken; a stuck buffer ends the run
    task px(input logic [7:0] l, input logic [7:0] c, input logic s, input logic e);
        int n;
        n = 0;
        in_valid <= 1'b1;
        in_pix <= {l, c, s, e};
        do begin
            @(posedge clk);
            n++;
        end while (in_ready !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            $display("unexpected at %0t: input stalled", $time);
            stop_test();
        end
    endtask : px

    // One line: raw start, m samples (sample 4 lifted by amp), raw end
    task run(input int ratio, input int acl, input logic [7:0] ctrl, input logic [7:0] base,
             input logic [7:0] amp, input int m, input logic [17:0] ls, input logic [17:0] lm,
             input logic [17:0] cs, input logic [17:0] cm);
        int n, t, last;
        logic [7:0] v;
        logic [17:0] sl, ml, sc, mc;
        wr(REG_RATIO_ADDR, 8'(ratio));
        wr(REG_ACL_ADDR, 8'(acl));
        wr(REG_CTRL_ADDR, ctrl);
        u_sink.got.delete();
        n = (m > acl) ? (m - 1 - acl) / ratio + 1 : 0;
        px(base, base, 1'b1, 1'b0);
        for (int k = 1; k <= m; k++) begin
            v = (k == 4) ? base + amp : base;
            px(v, v, 1'b0, 1'b0);
        end
        px(8'h5A, 8'hA5, 1'b0, 1'b1);
        in_valid <= 1'b0;
        t = 0;
        while (u_sink.got.size() < n + 2 && t < 500) begin
            @(posedge clk);
            t++;
        end
        // A missing output would leave the queue short; stop rather than index past it
        if (t >= 500) begin
            fail_count++;
            $display("unexpected at %0t: output missing", $time);
            stop_test();
        end
        repeat (4) @(posedge clk);
        last = u_sink.got.size() - 1;
        chk(18'(last + 1), 18'(n + 2));
        chk(u_sink.got[0], {base, base, 2'b10});
        chk(u_sink.got[last], {8'h5A, 8'hA5, 2'b01});
        sl = '0; ml = '0; sc = '0; mc = '0;
        for (int i = 1; i < last; i++) begin
            sl = sl + u_sink.got[i].luma;
            sc = sc + u_sink.got[i].chroma;
            if (u_sink.got[i].luma > ml) ml = u_sink.got[i].luma;
            if (u_sink.got[i].chroma > mc) mc = u_sink.got[i].chroma;
        end
        chk(sl, ls);
        chk(ml, lm);
        chk(sc, cs);
        chk(mc, cm);
    endtask : run

    // Register checks, flat-field gain cases, then impulse shapes under stall
    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        in_valid = 1'b0; in_pix = '0; slow = 1'b0; fail_count = 0; compares = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(REG_RATIO_ADDR, {2'h0, RATIO_RST});
        rdc(REG_ACL_ADDR, {2'h0, ACL_RST});
        rdc(REG_CTRL_ADDR, CTRL_RST);
        wr(REG_RATIO_ADDR, 8'hFF);
        rdc(REG_RATIO_ADDR, 8'h3F);
        wr(REG_ACL_ADDR, 8'hC5);
        rdc(REG_ACL_ADDR, 8'h05);
        wr(REG_CTRL_ADDR, 8'h5B);
        rdc(REG_CTRL_ADDR, 8'h5B);
        wr(8'hA3, 8'h77);
        rdc(8'hA3, 8'h00);
        run(1, 0, 8'h00, 100, 0, 8, 800, 100, 800, 100);
        run(2, 2, 8'h0A, 100, 0, 9, 400, 100, 400, 100);
        run(2, 2, 8'h02, 100, 0, 9, 300, 75, 300, 75);
        run(3, 5, 8'h0C, 160, 0, 12, 300, 100, 300, 100);
        run(2, 2, 8'h08, 100, 0, 9, 1020, 255, 1020, 255);
        run(35, 63, 8'h0F, 200, 0, 70, 196, 196, 196, 196);
        run(5, 8, 8'hAC, 100, 0, 12, 100, 100, 100, 100);
        run(3, 4, 8'hFB, 100, 0, 12, 300, 100, 300, 100);
        slow <= 1'b1;
        run(1, 0, 8'hC0, 0, 64, 12, 64, 64, 64, 16);
        run(1, 0, 8'h90, 0, 64, 12, 64, 32, 64, 20);
        run(1, 0, 8'h60, 0, 64, 12, 80, 36, 64, 32);
        run(1, 0, 8'h30, 0, 64, 12, 64, 16, 64, 64);
        stop_test();
    end
endmodule : testbench
